// ### rtl/sonf_pkg.sv
// shared constants and types of the serdes framer
package sonf_pkg;
  // framing bytes and the six-byte frame word
  localparam logic [7:0] A1_BYTE = 8'hF6;
  localparam logic [7:0] A2_BYTE = 8'h28;
  localparam logic [47:0] FRAME_WORD = {A1_BYTE, A1_BYTE, A1_BYTE, A2_BYTE, A2_BYTE, A2_BYTE};
  // register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  // control field positions and reset value
  localparam int CTRL_HIRATE = 0;
  localparam int CTRL_REFSEL = 1;
  localparam int CTRL_LINELOOP = 2;
  localparam int CTRL_LOCALLOOP = 3;
  localparam int CTRL_RCVTIM = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // status field positions
  localparam int STAT_LOS = 0;
  localparam int STAT_LOCK = 1;
  localparam int STAT_HIRATE = 2;
  localparam int STAT_RATIO_LSB = 8;
  // line and reference rates in kHz
  localparam int LINE_HI_KHZ = 622080;
  localparam int LINE_LO_KHZ = 155520;
  localparam int REF_HI_KHZ = 77760;
  localparam int REF_LO_KHZ = 19440;
  // bit tick spacing in hclk cycles, and multiplier feedback ratios
  localparam logic [2:0] TICK_DIV_HI = 3'h1;
  localparam logic [2:0] TICK_DIV_LO = 3'(LINE_HI_KHZ / LINE_LO_KHZ);
  localparam logic [5:0] FB_RATIO_HI_REF = 6'(LINE_HI_KHZ / REF_HI_KHZ);
  localparam logic [5:0] FB_RATIO_LO_REF = 6'(LINE_HI_KHZ / REF_LO_KHZ);
  // byte timing
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [2:0] BCLK_HIGH_FROM = 3'h4;
  localparam int HUNT_LEAD_BYTES = 4;
  // bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // framer state
  typedef enum logic {
    FRM_HUNT = 1'b0,
    FRM_LOCK = 1'b1
  } sonf_frm_t;
endpackage

// ### rtl/sonf_rx_align.sv
// receive deserializer with frame hunting and alignment
`timescale 1ns/10ps
`default_nettype none
module sonf_rx_align
  import sonf_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bit side
  input wire logic bit_tick,
  input wire logic bit_in,
  input wire logic los,
  input wire logic hunt,
  // byte side
  output logic [7:0] rx_parallel_out,
  output logic rx_byte_clock_out,
  output logic frame_pulse,
  output logic locked
);
  typedef struct packed {
    logic [47:0] win;
    logic [2:0] cnt;
    logic [7:0] data;
    logic fp;
    logic hunt_d;
    logic bclk;
    sonf_frm_t frm;
  } sonf_rx_st_t;

  sonf_rx_st_t state_ff;
  sonf_rx_st_t nxt_state;
  logic [47:0] new_win;

  always_comb begin
    nxt_state = state_ff;
    new_win = {state_ff.win[46:0], bit_in};
    if (bit_tick) begin
      nxt_state.win = new_win;
      nxt_state.hunt_d = hunt;
      nxt_state.cnt = state_ff.cnt + 3'h1;
      if (los || (hunt && !state_ff.hunt_d)) begin
        nxt_state.frm = FRM_HUNT;
      end
      if ((hunt || state_ff.hunt_d) && new_win == FRAME_WORD) begin
        nxt_state.cnt = 3'h0;
        nxt_state.data = los ? 8'h00 : new_win[7:0];
        nxt_state.fp = !los;
        nxt_state.frm = FRM_LOCK;
      end else if (state_ff.cnt == BYTE_LAST) begin
        // byte assembly, forced low on loss
        nxt_state.data = los ? 8'h00 : new_win[7:0];
        nxt_state.fp = 1'b0;
      end
      nxt_state.bclk = nxt_state.cnt >= BCLK_HIGH_FROM;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rx_parallel_out = state_ff.data;
  assign rx_byte_clock_out = state_ff.bclk;
  assign frame_pulse = state_ff.fp;
  assign locked = state_ff.frm == FRM_LOCK;

  AST_FP_A2: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(frame_pulse) |-> rx_parallel_out == A2_BYTE)
    else $error("frame pulse not with third A2 byte");
  AST_FP_HUNT: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(frame_pulse) |-> ($past(hunt) || $past(state_ff.hunt_d)))
    else $error("frame pulse without hunt request");
  AST_FP_ONE: assert property (@(posedge hclk) disable iff (!hresetn)
    (frame_pulse && bit_tick && state_ff.cnt == BYTE_LAST && !hunt && !state_ff.hunt_d)
    |=> !frame_pulse)
    else $error("frame pulse longer than one byte");
endmodule
`default_nettype wire

// ### rtl/sonf_top.sv
// serdes framer top: bus registers, pin sync, clock sources and loopbacks
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module sonf_top
  import sonf_pkg::*;
#(
  parameter bit LOS_ACTIVE_HIGH = 1'b1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // parallel partner side
  input wire logic [7:0] tx_parallel_in,
  output logic tx_byte_clock_out,
  output logic [7:0] rx_parallel_out,
  output logic rx_byte_clock_out,
  output logic frame_pulse,
  input wire logic frame_hunt_request,
  // serial line side
  output logic serial_tx_out,
  input wire logic serial_rx_in,
  input wire logic serial_rx_clock_in,
  input wire logic signal_loss_input
);
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic rxd1;
    logic rxd2;
    logic rxc1;
    logic rxc2;
    logic rxc3;
    logic los1;
    logic los2;
    logic [2:0] div;
    logic txo;
  } sonf_top_st_t;

  sonf_top_st_t state_ff;
  sonf_top_st_t nxt_state;

  logic los;
  logic hi_rate;
  logic ref_sel;
  logic line_loop;
  logic local_loop;
  logic rcv_tim;
  logic mult_tick;
  logic rx_edge;
  logic tx_tick;
  logic rx_tick;
  logic rx_bit;
  logic ser_bit;
  logic locked;
  logic addr_phase;

  function automatic logic [5:0] fb_ratio(input logic refsel);
    return refsel ? FB_RATIO_LO_REF : FB_RATIO_HI_REF;
  endfunction

  // register read decode
  function automatic logic [31:0] reg_read(
    input logic [7:0] addr,
    input logic [CTRL_W-1:0] ctrl,
    input logic los_now,
    input logic lock_now
  );
    logic [31:0] val;
    val = 32'h0000_0000;
    if (addr == CTRL_OFS) begin
      val[CTRL_W-1:0] = ctrl;
    end else if (addr == STAT_OFS) begin
      val[STAT_LOS] = los_now;
      val[STAT_LOCK] = lock_now;
      val[STAT_HIRATE] = ctrl[CTRL_HIRATE];
      val[STAT_RATIO_LSB +: 6] = fb_ratio(ctrl[CTRL_REFSEL]);
    end
    return val;
  endfunction

  assign hi_rate = state_ff.ctrl[CTRL_HIRATE];
  assign ref_sel = state_ff.ctrl[CTRL_REFSEL];
  assign line_loop = state_ff.ctrl[CTRL_LINELOOP];
  assign local_loop = state_ff.ctrl[CTRL_LOCALLOOP];
  assign rcv_tim = state_ff.ctrl[CTRL_RCVTIM];

  assign los = state_ff.los2 == LOS_ACTIVE_HIGH;

  // multiplier bit tick by line rate
  assign mult_tick = state_ff.div == ((hi_rate ? TICK_DIV_HI : TICK_DIV_LO) - 3'h1);

  assign rx_edge = state_ff.rxc2 && !state_ff.rxc3;

  assign tx_tick = rcv_tim ? rx_edge : mult_tick;

  always_comb begin
    if (local_loop) begin
      rx_tick = tx_tick;
      rx_bit = ser_bit;
    end else if (los) begin
      rx_tick = rcv_tim ? tx_tick : mult_tick;
      rx_bit = state_ff.rxd2;
    end else begin
      rx_tick = rx_edge;
      rx_bit = state_ff.rxd2;
    end
  end

  assign addr_phase = hsel && htrans == HTRANS_NONSEQ && hready;

  always_comb begin
    nxt_state = state_ff;
    // pin synchronisers
    nxt_state.rxd1 = serial_rx_in;
    nxt_state.rxd2 = state_ff.rxd1;
    nxt_state.rxc1 = serial_rx_clock_in;
    nxt_state.rxc2 = state_ff.rxc1;
    nxt_state.rxc3 = state_ff.rxc2;
    nxt_state.los1 = signal_loss_input;
    nxt_state.los2 = state_ff.los1;
    nxt_state.div = mult_tick ? 3'h0 : state_ff.div + 3'h1;
    // bus data phase write
    nxt_state.wr_pend = 1'b0;
    if (state_ff.wr_pend && state_ff.wr_addr == CTRL_OFS) begin
      nxt_state.ctrl = hwdata[CTRL_W-1:0];
    end
    // bus address phase
    nxt_state.rdata = 32'h0000_0000;
    if (addr_phase) begin
      if (hwrite) begin
        nxt_state.wr_pend = hsize == HSIZE_WORD;
        nxt_state.wr_addr = haddr[7:0];
      end else begin
        nxt_state.rdata = reg_read(haddr[7:0], state_ff.ctrl, los, locked);
      end
    end
    nxt_state.txo = line_loop ? state_ff.rxd2 : ser_bit;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= '0;
      state_ff.ctrl <= CTRL_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_ff.rdata;
  assign serial_tx_out = state_ff.txo;

  sonf_tx_ser u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .bit_tick(tx_tick),
    .tx_parallel_in(tx_parallel_in),
    .tx_byte_clock_out(tx_byte_clock_out),
    .ser_bit(ser_bit)
  );

  sonf_rx_align u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .bit_tick(rx_tick),
    .bit_in(rx_bit),
    .los(los),
    .hunt(frame_hunt_request),
    .rx_parallel_out(rx_parallel_out),
    .rx_byte_clock_out(rx_byte_clock_out),
    .frame_pulse(frame_pulse),
    .locked(locked)
  );

  AST_LOS_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    ($changed(rx_parallel_out) && rx_parallel_out != 8'h00) |-> !$past(los))
    else $error("receive data not forced low on loss");
  AST_LINE_LOOP: assert property (@(posedge hclk) disable iff (!hresetn)
    line_loop |=> serial_tx_out == $past(state_ff.rxd2))
    else $error("line loopback data not on serial output");
  AST_CTRL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff.wr_pend && state_ff.wr_addr == CTRL_OFS)
    |=> state_ff.ctrl == $past(hwdata[CTRL_W-1:0]))
    else $error("control write not taken");
  AST_MULT_TICK: assert property (@(posedge hclk) disable iff (!hresetn)
    (mult_tick && !hi_rate && !state_ff.wr_pend) |=> !mult_tick [*3])
    else $error("low rate bit tick spacing wrong");
  AST_LOS_CLOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    (los && !local_loop && !rcv_tim) |-> rx_tick == mult_tick)
    else $error("receive not clocked from multiplier on loss");
  AST_LOOP_TIMING: assert property (@(posedge hclk) disable iff (!hresetn)
    rcv_tim |-> tx_tick == rx_edge)
    else $error("recovered timing not driving transmit");
  AST_LOCAL_FEED: assert property (@(posedge hclk) disable iff (!hresetn)
    local_loop |-> (rx_bit == ser_bit && rx_tick == tx_tick))
    else $error("local loopback not feeding receive");
  AST_IDLE_RDATA: assert property (@(posedge hclk) disable iff (!hresetn)
    !addr_phase |=> hrdata == 32'h0000_0000)
    else $error("read data not zero outside data phase");
endmodule
`default_nettype wire

// ### rtl/sonf_tx_ser.sv
// transmit byte capture and msb-first serializer
`timescale 1ns/10ps
`default_nettype none
module sonf_tx_ser
  import sonf_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bit timing
  input wire logic bit_tick,
  // byte side
  input wire logic [7:0] tx_parallel_in,
  output logic tx_byte_clock_out,
  // serial side
  output logic ser_bit
);
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic bclk;
  } sonf_ser_st_t;

  sonf_ser_st_t state_ff;
  sonf_ser_st_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (bit_tick) begin
      nxt_state.cnt = state_ff.cnt + 3'h1;
      if (state_ff.cnt == BYTE_LAST) begin
        nxt_state.sh = tx_parallel_in;
      end else begin
        nxt_state.sh = {state_ff.sh[6:0], 1'b0};
      end
      nxt_state.bclk = nxt_state.cnt < BCLK_HIGH_FROM;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign tx_byte_clock_out = state_ff.bclk;
  assign ser_bit = state_ff.sh[7];

  AST_TX_MSB: assert property (@(posedge hclk) disable iff (!hresetn)
    (bit_tick && state_ff.cnt == BYTE_LAST) |=> ser_bit == $past(tx_parallel_in[7]))
    else $error("first serial bit is not the byte msb");
endmodule
`default_nettype wire

// ### verif/sonet_serdes_framer_bench.sv
// testbench of the serdes framer
`timescale 1ns/10ps
`default_nettype none
module sonet_serdes_framer_bench;
  import sonf_pkg::*;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, fp_len;
  logic [1:0] htrans, rxc_div;
  logic [2:0] hsize;
  logic [7:0] tx_parallel_in, rx_parallel_out, rx_cnt, c0;
  logic [15:0] rx_hist;
  logic tx_byte_clock_out, rx_byte_clock_out, frame_pulse, frame_hunt_request;
  logic serial_tx_out, serial_rx_in, serial_rx_clock_in, signal_loss_input, tbc_q, run_rxc;
  int fails, n_compared, n_tx, n_fp, n_tbc, t0;
  logic [36:0] rows [4] = '{{5'h00, 32'h800}, {5'h01, 32'h804}, {5'h02, 32'h2000},
    {5'h03, 32'h2004}};
  assign hready = hreadyout;
  always #4 hclk = !hclk;
  sonf_top sonf_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx_parallel_in(tx_parallel_in),
    .tx_byte_clock_out(tx_byte_clock_out), .rx_parallel_out(rx_parallel_out),
    .rx_byte_clock_out(rx_byte_clock_out), .frame_pulse(frame_pulse),
    .frame_hunt_request(frame_hunt_request), .serial_tx_out(serial_tx_out),
    .serial_rx_in(serial_rx_in), .serial_rx_clock_in(serial_rx_clock_in),
    .signal_loss_input(signal_loss_input));
  sonf_partner sonf_partner_inst (.hclk(hclk), .hresetn(hresetn),
    .tx_byte_clock_out(tx_byte_clock_out), .tx_parallel_in(tx_parallel_in),
    .rx_parallel_out(rx_parallel_out), .rx_byte_clock_out(rx_byte_clock_out),
    .rx_hist(rx_hist), .rx_cnt(rx_cnt));
  task automatic close_out(input bit hung);
    if (hung)
      fails++;
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
      close_out(1'b1);
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      input logic [31:0] m, input logic [31:0] e);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    chk("hresp", 32'h0, {31'h0, hresp});
    if (!wr)
      chk("hrdata", e, hrdata & m);
  endtask
  // line clock, running only while a line scenario needs it
  always @(posedge hclk) begin
    rxc_div <= rxc_div + 2'h1;
    if (run_rxc && rxc_div == 2'h3)
      serial_rx_clock_in <= !serial_rx_clock_in;
  end
  // serial frame word, byte clock rises and frame pulse watch
  logic [47:0] tx_sr;
  always @(posedge hclk) begin
    tx_sr <= {tx_sr[46:0], serial_tx_out};
    tbc_q <= tx_byte_clock_out;
    if (tx_sr === FRAME_WORD)
      n_tx++;
    if (tx_byte_clock_out === 1'b1 && tbc_q === 1'b0)
      n_tbc++;
    if (frame_pulse === 1'b1) begin
      if (fp_len == 0)
        chk("rx byte at pulse", 32'(A2_BYTE), 32'(rx_parallel_out));
      fp_len <= fp_len + 1;
    end else if (fp_len != 0) begin
      chk("pulse length", 32'h8, fp_len);
      n_fp++;
      fp_len <= 0;
    end
  end
  initial begin
    {hresetn, hsel, hwrite, frame_hunt_request, serial_rx_in, signal_loss_input} = '0;
    {serial_rx_clock_in, run_rxc, rxc_div, htrans, hsize, haddr, hwdata, fp_len} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 32'(CTRL_OFS), 0, 32'h1F, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 32'(CTRL_OFS), 32'(rows[i][36:32]), 0, 0);
      bus(1'b0, 32'(CTRL_OFS), 0, 32'h1F, 32'(rows[i][36:32]));
      bus(1'b0, 32'(STAT_OFS), 0, 32'h3F05, rows[i][31:0]);
    end
    bus(1'b1, 32'h40, 32'h1F, 0, 0);
    bus(1'b0, 32'h40, 0, 32'hFFFFFFFF, 32'h0);
    bus(1'b0, 32'(CTRL_OFS), 0, 32'h1F, 32'h3);
    bus(1'b1, 32'(CTRL_OFS), 32'h09, 0, 0);
    repeat (600) @(posedge hclk);
    chk("pulses without hunt", 0, n_fp);
    chk("tx frame word seen", 1, 32'(n_tx > 0));
    // hunt raised well ahead of the next boundary
    frame_hunt_request <= 1'b1;
    for (int k = 0; k < 2000 && n_fp < 1; k++) @(posedge hclk);
    if (n_fp < 1)
      close_out(1'b1);
    c0 = rx_cnt;
    for (int k = 0; k < 200 && rx_cnt != c0 + 8'h02; k++) @(posedge hclk);
    if (rx_cnt != c0 + 8'h02)
      close_out(1'b1);
    chk("bytes after frame", {16'h0, 8'h3C, 8'hC3}, 32'(rx_hist));
    signal_loss_input <= 1'b1;
    repeat (24) @(posedge hclk);
    bus(1'b0, 32'(STAT_OFS), 0, 32'h1, 32'h1);
    t0 = n_fp;
    for (int k = 0; k < 300; k++) begin
      @(posedge hclk);
      chk("rx data in loss", 0, 32'(rx_parallel_out));
    end
    chk("pulses in loss", t0, n_fp);
    signal_loss_input <= 1'b0;
    frame_hunt_request <= 1'b0;
    run_rxc <= 1'b1;
    bus(1'b1, 32'(CTRL_OFS), 32'h04, 0, 0);
    serial_rx_in <= 1'b1;
    repeat (40) @(posedge hclk);
    chk("line loop high", 1, 32'(serial_tx_out));
    serial_rx_in <= 1'b0;
    repeat (40) @(posedge hclk);
    chk("line loop low", 0, 32'(serial_tx_out));
    run_rxc <= 1'b0;
    bus(1'b1, 32'(CTRL_OFS), 32'h10, 0, 0);
    repeat (40) @(posedge hclk);
    t0 = n_tbc;
    repeat (200) @(posedge hclk);
    chk("byte clock without line clock", t0, n_tbc);
    run_rxc <= 1'b1;
    repeat (600) @(posedge hclk);
    chk("byte clock from line clock", 1, 32'(n_tbc > t0));
    close_out(1'b0);
  end
  initial begin
    repeat (100000) @(posedge hclk);
    close_out(1'b1);
  end
endmodule
`default_nettype wire

// ### verif/sonf_partner.sv
// partner framer model: sends a framed byte stream and collects received bytes
`timescale 1ns/10ps
`default_nettype none
module sonf_partner
  import sonf_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // byte side
  input wire logic tx_byte_clock_out,
  output logic [7:0] tx_parallel_in,
  input wire logic [7:0] rx_parallel_out,
  input wire logic rx_byte_clock_out,
  // collected bytes
  output logic [15:0] rx_hist,
  output logic [7:0] rx_cnt
);
  logic [7:0] frm [12] = '{8'h00, 8'h55, A1_BYTE, A1_BYTE, A1_BYTE, A2_BYTE, A2_BYTE,
    A2_BYTE, 8'h3C, 8'hC3, 8'h00, 8'h00};
  logic tbc_q;
  logic rbc_q;
  logic [3:0] idx;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tbc_q <= 1'b0;
      rbc_q <= 1'b0;
      idx <= 4'h0;
      tx_parallel_in <= 8'h00;
      rx_hist <= 16'h0000;
      rx_cnt <= 8'h00;
    end else begin
      tbc_q <= tx_byte_clock_out;
      rbc_q <= rx_byte_clock_out;
      if (tx_byte_clock_out && !tbc_q) begin
        tx_parallel_in <= frm[idx];
        idx <= (idx == 4'hB) ? 4'h0 : idx + 4'h1;
      end
      if (rx_byte_clock_out && !rbc_q) begin
        rx_hist <= {rx_hist[7:0], rx_parallel_out};
        rx_cnt <= rx_cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire
